// file: pkg/emb_pkg.sv
// package: register map, fields, reset values and types for the memory bus
package emb_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] OFS_PROM_IO    = 4'h0;
  localparam logic [3:0] OFS_SRAM_SDRAM = 4'h4;
  localparam logic [3:0] OFS_REFRESH    = 4'h8;
  localparam logic [3:0] OFS_EDAC_TEST  = 4'hC;

  // ************************************************************
  // first configuration register fields
  // ************************************************************
  localparam int B1_PROM_RDY  = 30;
  localparam int B1_ASYNC_RDY = 29;
  localparam int B1_IOW_HI    = 28;
  localparam int B1_IOW_LO    = 27;
  localparam int B1_IO_RDY    = 26;
  localparam int B1_BERR_EN   = 25;
  localparam int B1_IOWS_HI   = 23;
  localparam int B1_IOWS_LO   = 20;
  localparam int B1_IO_EN     = 19;
  localparam int B1_PBS_HI    = 17;
  localparam int B1_PBS_LO    = 14;
  localparam int B1_PROM_WRITE_EN      = 11;
  localparam int B1_PW_HI     = 9;
  localparam int B1_PW_LO     = 8;
  localparam int B1_PWWS_HI   = 7;
  localparam int B1_PWWS_LO   = 4;
  localparam int B1_PRWS_HI   = 3;
  localparam int B1_PRWS_LO   = 0;

  // ************************************************************
  // second configuration register fields
  // ************************************************************
  localparam int B2_REF_EN   = 31;
  localparam int B2_TRP      = 30;
  localparam int B2_TRFC_HI  = 29;
  localparam int B2_TRFC_LO  = 27;
  localparam int B2_CAS      = 26;
  localparam int B2_SBS_HI   = 25;
  localparam int B2_SBS_LO   = 23;
  localparam int B2_COL_HI   = 22;
  localparam int B2_COL_LO   = 21;
  localparam int B2_CMD_HI   = 20;
  localparam int B2_CMD_LO   = 19;
  localparam int B2_WIDE     = 18;
  localparam int B2_PAGE     = 17;
  localparam int B2_SD_EN    = 14;
  localparam int B2_SRAM_DIS = 13;
  localparam int B2_RBS_HI   = 12;
  localparam int B2_RBS_LO   = 9;
  localparam int B2_RAM_RDY  = 7;
  localparam int B2_RMW      = 6;
  localparam int B2_RW_HI    = 5;
  localparam int B2_RW_LO    = 4;
  localparam int B2_RWWS_HI  = 3;
  localparam int B2_RWWS_LO  = 2;
  localparam int B2_RRWS_HI  = 1;
  localparam int B2_RRWS_LO  = 0;

  // ************************************************************
  // reset values and encodings
  // ************************************************************
  localparam logic [3:0]  WS_MAX_CODE   = 4'hF;
  localparam logic [3:0]  PBS_RESET     = 4'h0;
  localparam logic [31:0] CFG1_RESET    = 32'h0000_00FF;
  localparam logic [31:0] CFG2_RESET    = 32'h0000_0000;
  localparam logic [31:0] CFG1_RW_MASK  = 32'h7EFB_CBFF;
  localparam logic [31:0] CFG2_RW_MASK  = 32'hFFFA_7EFF;
  localparam logic [1:0]  CMD_NONE      = 2'h0;
  localparam logic [1:0]  CMD_PRECHARGE = 2'h1;
  localparam logic [1:0]  CMD_REFRESH   = 2'h2;
  localparam logic [1:0]  CMD_LOAD_MODE = 2'h3;
  localparam logic [4:0]  PROM_WS_SHIFT = 5'h1;
  localparam logic [4:0]  LAST_BYTE     = 5'h3;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    EMB_AREA_PROM = 2'h0,
    EMB_AREA_IO   = 2'h1,
    EMB_AREA_RAM  = 2'h2,
    EMB_AREA_RAM4 = 2'h3
  } emb_area_e;

  typedef enum logic [3:0] {
    EMB_IDLE  = 4'b0001,
    EMB_WAIT  = 4'b0010,
    EMB_READY = 4'b0100,
    EMB_DONE  = 4'b1000
  } emb_state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    emb_area_e   area;
    logic        byte_mode;
    logic [1:0]  byte_idx;
  } emb_req_s;

  typedef struct packed {
    logic        done;
    logic        error;
  } emb_rsp_s;

endpackage : emb_pkg

// file: rtl/emb_ctrl.sv
// memory bus ready stretching, access errors and configuration registers
`timescale 1ns/1ps
module emb_ctrl #(
  parameter logic WIDE_SDRAM = 1'b0        // 64-bit sdram bus built in
) (
  input  wire logic              clk_sys,      // system clock
  input  wire logic              srst,         // synchronous reset
  input  wire logic              reg_sel,      // register access strobe
  input  wire logic              reg_write,    // 1 write, 0 read
  input  wire logic [3:0]        reg_addr,     // byte offset
  input  wire logic [31:0]       reg_wdata,    // write data
  output logic [31:0]            reg_rdata,    // read data
  input  wire logic [1:0]        strap_width,  // prom width strap
  input  wire emb_pkg::emb_req_s req,          // access start request
  output emb_pkg::emb_rsp_s      rsp,          // access end and error
  input  wire logic              ready_n,      // external bus ready, low
  input  wire logic              berr_n,       // external access error, low
  output logic                   acc_busy,     // access in progress
  input  wire logic              cmd_done,     // sdram command executed
  output logic [1:0]             sdram_cmd,    // pending sdram command
  output logic                   ram4_en,      // fifth sram bank usable
  output logic                   sram_en,      // sram banks usable
  output logic [31:0]            cfg1,         // first config register
  output logic [31:0]            cfg2          // second config register
);

  // ************************************************************
  // register file
  // ************************************************************
  logic [31:0] cfg1_q;
  logic [31:0] cfg2_q;
  logic        strap_load_q;
  logic        wr1;
  logic        wr2;

  assign wr1 = reg_sel && reg_write && reg_addr == emb_pkg::OFS_PROM_IO;
  assign wr2 = reg_sel && reg_write && reg_addr == emb_pkg::OFS_SRAM_SDRAM;

  // straps caught by a clocked process after reset release
  always_ff @(posedge clk_sys) begin
    strap_load_q <= srst;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg1_q <= emb_pkg::CFG1_RESET;
      cfg1_q[emb_pkg::B1_PBS_HI:emb_pkg::B1_PBS_LO] <=
        emb_pkg::PBS_RESET;
    end else if (wr1) begin
      cfg1_q <= reg_wdata & emb_pkg::CFG1_RW_MASK;
    end else if (strap_load_q) begin
      cfg1_q[emb_pkg::B1_PW_HI:emb_pkg::B1_PW_LO] <= strap_width;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg2_q <= emb_pkg::CFG2_RESET;
    end else if (wr2) begin
      cfg2_q <= reg_wdata & emb_pkg::CFG2_RW_MASK;
    end else if (cmd_done) begin
      cfg2_q[emb_pkg::B2_CMD_HI:emb_pkg::B2_CMD_LO] <=
        emb_pkg::CMD_NONE;
    end
  end

  always_comb begin
    cfg1 = cfg1_q;
    cfg2 = cfg2_q;
    cfg2[emb_pkg::B2_WIDE] = WIDE_SDRAM;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_sel && !reg_write) begin
      unique case (reg_addr)
        emb_pkg::OFS_PROM_IO:    reg_rdata <= cfg1;
        emb_pkg::OFS_SRAM_SDRAM: reg_rdata <= cfg2;
        default:                 reg_rdata <= '0;
      endcase
    end
  end

  assign sdram_cmd = cfg2_q[emb_pkg::B2_CMD_HI:emb_pkg::B2_CMD_LO];
  assign ram4_en = !cfg2_q[emb_pkg::B2_SD_EN];
  assign sram_en = !(cfg2_q[emb_pkg::B2_SD_EN] &&
                     cfg2_q[emb_pkg::B2_SRAM_DIS]);

  // ************************************************************
  // input sampling
  // ************************************************************
  logic rdy_meta_q;
  logic rdy_sync_q;
  logic rdy_now_q;
  logic rdy_seen;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdy_meta_q <= 1'b0;
      rdy_sync_q <= 1'b0;
      rdy_now_q  <= 1'b0;
    end else begin
      rdy_meta_q <= !ready_n;
      rdy_sync_q <= rdy_meta_q;
      rdy_now_q  <= !ready_n;
    end
  end

  assign rdy_seen = cfg1_q[emb_pkg::B1_ASYNC_RDY] ? rdy_sync_q
                                                  : rdy_now_q;

  // ************************************************************
  // waitstate selection
  // ************************************************************
  function automatic logic [4:0] prom_ws(input logic [3:0] code);
    prom_ws = {1'b0, code} << emb_pkg::PROM_WS_SHIFT;
  endfunction : prom_ws

  logic [4:0] ws_sel;
  logic       rdy_en_sel;

  always_comb begin
    ws_sel = '0;
    rdy_en_sel = 1'b0;
    unique case (req.area)
      emb_pkg::EMB_AREA_PROM: begin
        ws_sel = req.write ?
          prom_ws(cfg1_q[emb_pkg::B1_PWWS_HI:emb_pkg::B1_PWWS_LO]) :
          prom_ws(cfg1_q[emb_pkg::B1_PRWS_HI:emb_pkg::B1_PRWS_LO]);
        rdy_en_sel = cfg1_q[emb_pkg::B1_PROM_RDY];
      end
      emb_pkg::EMB_AREA_IO: begin
        ws_sel = {1'b0, cfg1_q[emb_pkg::B1_IOWS_HI:emb_pkg::B1_IOWS_LO]};
        rdy_en_sel = cfg1_q[emb_pkg::B1_IO_RDY];
      end
      emb_pkg::EMB_AREA_RAM: begin
        ws_sel = req.write ?
          {3'h0, cfg2_q[emb_pkg::B2_RWWS_HI:emb_pkg::B2_RWWS_LO]} :
          {3'h0, cfg2_q[emb_pkg::B2_RRWS_HI:emb_pkg::B2_RRWS_LO]};
        rdy_en_sel = 1'b0;
      end
      emb_pkg::EMB_AREA_RAM4: begin
        ws_sel = req.write ?
          {3'h0, cfg2_q[emb_pkg::B2_RWWS_HI:emb_pkg::B2_RWWS_LO]} :
          {3'h0, cfg2_q[emb_pkg::B2_RRWS_HI:emb_pkg::B2_RRWS_LO]};
        rdy_en_sel = cfg2_q[emb_pkg::B2_RAM_RDY];
      end
    endcase
  end

  // ************************************************************
  // access sequencer
  // ************************************************************
  emb_pkg::emb_state_e state_q;
  logic [4:0]          ws_cnt_q;
  logic                rdy_en_q;
  logic                last_q;
  logic                err_q;
  logic                done_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q  <= emb_pkg::EMB_IDLE;
      ws_cnt_q <= '0;
      rdy_en_q <= 1'b0;
      last_q   <= 1'b0;
    end else begin
      unique case (state_q)
        emb_pkg::EMB_IDLE: begin
          if (req.valid) begin
            ws_cnt_q <= ws_sel;
            rdy_en_q <= rdy_en_sel;
            last_q   <= !req.byte_mode ||
                        {3'h0, req.byte_idx} == emb_pkg::LAST_BYTE;
            state_q  <= emb_pkg::EMB_WAIT;
          end
        end
        emb_pkg::EMB_WAIT: begin
          if (ws_cnt_q != '0) begin
            ws_cnt_q <= ws_cnt_q - 5'h1;
          end else if (rdy_en_q) begin
            state_q <= emb_pkg::EMB_READY;
          end else begin
            state_q <= emb_pkg::EMB_DONE;
          end
        end
        emb_pkg::EMB_READY: begin
          if (rdy_seen) begin
            state_q <= emb_pkg::EMB_DONE;
          end
        end
        emb_pkg::EMB_DONE: begin
          state_q <= emb_pkg::EMB_IDLE;
        end
      endcase
    end
  end

  // error sampled on the final edge of the access, last byte only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= state_q == emb_pkg::EMB_DONE;
      err_q  <= state_q == emb_pkg::EMB_DONE && last_q && !berr_n &&
                cfg1_q[emb_pkg::B1_BERR_EN];
    end
  end

  assign rsp.done  = done_q;
  assign rsp.error = err_q;
  assign acc_busy  = state_q != emb_pkg::EMB_IDLE;

endmodule : emb_ctrl

// file: tb/emb_ctrl_sva.sv
// checker: port-level properties of the memory bus block
`timescale 1ns/1ps
module emb_ctrl_chk #(
  parameter logic WIDE_SDRAM = 1'b0  // wide sdram built in
) (
  input wire logic              clk_sys,    // clock
  input wire logic              srst,       // reset
  input wire logic              reg_sel,    // strobe
  input wire logic              reg_write,  // write
  input wire logic [3:0]        reg_addr,   // offset
  input wire emb_pkg::emb_req_s req,        // request
  input wire emb_pkg::emb_rsp_s rsp,        // response
  input wire logic              berr_n,     // error in
  input wire logic              acc_busy,   // busy
  input wire logic              cmd_done,   // cmd done
  input wire logic [1:0]        sdram_cmd,  // cmd field
  input wire logic              ram4_en,    // bank 4
  input wire logic              sram_en,    // sram
  input wire logic [31:0]       cfg1,       // cfg 1
  input wire logic [31:0]       cfg2        // cfg 2
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  sequence s_start;
    req.valid && !acc_busy;
  endsequence
  sequence s_ram;
    s_start ##0 req.area == emb_pkg::EMB_AREA_RAM;
  endsequence
  AST_ERR_DONE: assert property (rsp.error |-> rsp.done)
    else $error("error without done");
  AST_ERR_EN: assert property (rsp.error |-> $past(cfg1[25]))
    else $error("error while disabled");
  AST_ERR_SRC: assert property (rsp.error |-> !$past(berr_n))
    else $error("error without cause");
  AST_DONE_IDLE: assert property (rsp.done |-> !acc_busy)
    else $error("busy at done");
  AST_MIN_LEN: assert property (s_start |=> !rsp.done [*2])
    else $error("access too short");
  AST_RAM_LEN: assert property (s_ram |-> ##[3:6] rsp.done)
    else $error("ram access length");
  AST_RST_VAL: assert property ($fell(srst) |->
    (cfg1 & ~32'h0000_0300) == emb_pkg::CFG1_RESET &&
    (cfg2 & ~32'h0004_0000) == emb_pkg::CFG2_RESET)
    else $error("reset value");
  AST_CMD_CLR: assert property (cmd_done &&
    !(reg_sel && reg_write && reg_addr == emb_pkg::OFS_SRAM_SDRAM)
    |=> sdram_cmd == emb_pkg::CMD_NONE)
    else $error("command not cleared");
  AST_BANKS: assert property (ram4_en == !cfg2[14] &&
    sram_en == !(cfg2[14] && cfg2[13]))
    else $error("bank enables");
  AST_WIDE: assert property (cfg2[18] == WIDE_SDRAM)
    else $error("wide flag");
endmodule : emb_ctrl_chk

// file: tb/emb_mem_model.sv
// partner: external device answering with bus ready and access error
`timescale 1ns/1ps
module emb_mem_model (
  input  wire logic       clk_sys,   // clock
  input  wire logic       acc_busy,  // access running
  input  wire logic [7:0] rdy_dly,   // cycles before ready
  input  wire logic       berr_req,  // signal access error
  output logic            ready_n,   // bus ready, low
  output logic            berr_n     // access error, low
);
  logic [7:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    cnt_q <= acc_busy ? cnt_q + 8'h01 : 8'h00;
  end
  // ready held to end of access, pull-up once released
  assign ready_n = !(acc_busy && cnt_q >= rdy_dly);
  assign berr_n = !(acc_busy && berr_req);
endmodule : emb_mem_model

// file: tb/external_memory_bus_ready_and_config_tb_top.sv
// bench: registers, access timing, bus ready and access errors
`timescale 1ns/1ps
module external_memory_bus_ready_and_config_tb_top;
  logic              clk_sys, srst, reg_sel, reg_write, cmd_done, wr;
  logic              ready_n, berr_n, acc_busy, ram4_en, sram_en;
  logic              berr_req, err;
  logic [1:0]        strap_width, sdram_cmd;
  logic [3:0]        reg_addr;
  logic [7:0]        rdy_dly;
  logic [31:0]       reg_wdata, reg_rdata, cfg1, cfg2, rd, w1, w2;
  logic [6:0]        tbl [4] = '{7'h68, 7'h54, 7'h77, 7'h00};
  emb_pkg::emb_req_s req;
  emb_pkg::emb_rsp_s rsp;
  int                error_cnt, checks_done, lat, ls [4];

  emb_ctrl u_emb_ctrl (.clk_sys, .srst, .reg_sel, .reg_write, .reg_addr,
    .reg_wdata, .reg_rdata, .strap_width, .req, .rsp, .ready_n, .berr_n,
    .acc_busy, .cmd_done, .sdram_cmd, .ram4_en, .sram_en, .cfg1, .cfg2);
  emb_mem_model u_emb_mem_model (.clk_sys, .acc_busy, .rdy_dly,
    .berr_req, .ready_n, .berr_n);

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_sel = 1'b1;
    reg_write = w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_sel = 1'b0;
    rd = reg_rdata;
  endtask : rg

  task automatic acc(input logic [1:0] ar, input logic w, input logic [2:0] b);
    @(negedge clk_sys);
    req = '{1'b1, w, emb_pkg::emb_area_e'(ar), b[2], b[1:0]};
    for (lat = 0; lat < 200; lat++) begin
      @(negedge clk_sys);
      req.valid = 1'b0;
      if (rsp.done === 1'b1) break;
    end
    err = rsp.error;
    if (lat == 200) begin
      error_cnt++;
      $display("[ERR] %0t access hung", $time);
      finish_test();
    end
  endtask : acc

  // waitstates expected from the values last written
  function automatic int ews(input logic [1:0] ar, input logic w);
    case (ar)
      2'h0: return 2 * int'(w ? w1[7:4] : w1[3:0]);
      2'h1: return int'(w1[23:20]);
      default: return int'(w ? w2[3:2] : w2[1:0]);
    endcase
  endfunction : ews

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    srst = 1'b1;
    {reg_sel, reg_write, cmd_done, berr_req} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    strap_width = 2'h2;
    req = '0;
    rdy_dly = 8'hFF;
    error_cnt = 0;
    checks_done = 0;
    rd = $urandom(32'h0000_000B);
    repeat (16) @(negedge clk_sys);
    srst = 1'b0;
    rg(1'b0, 4'h0, 32'h0);
    chk(rd, 32'h0000_02FF);
    rg(1'b0, 4'h4, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      w1 = $urandom;
      w2 = $urandom;
      rg(1'b1, 4'h0, w1);
      rg(1'b0, 4'h0, 32'h0);
      chk(rd, w1 & emb_pkg::CFG1_RW_MASK);
      rg(1'b1, 4'h4, w2);
      rg(1'b0, 4'h4, 32'h0);
      chk(rd, w2 & emb_pkg::CFG2_RW_MASK);
      rg(1'b1, i[0] ? 4'hC : 4'h8, w1);
      rg(1'b0, i[0] ? 4'hC : 4'h8, 32'h0);
      chk(rd, 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      rg(1'b1, 4'h4, 32'(k) << 19 | 32'(k) << 13);
      chk(32'(sdram_cmd), 32'(k));
      chk(32'(ram4_en), 32'(k < 2));
      chk(32'(sram_en), 32'(k != 3));
      cmd_done = 1'b1;
      @(negedge clk_sys);
      cmd_done = 1'b0;
      chk(32'(sdram_cmd), 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      w1 = i < 4 ? 32'h00F8_08FF : $urandom & 32'h00F0_00FF | 32'h0008_0800;
      w2 = i < 4 ? 32'h0000_000F : $urandom & 32'h0000_000F;
      wr = 1'($urandom);
      rg(1'b1, 4'h0, w1);
      rg(1'b1, 4'h4, w2);
      acc(i[1:0], wr, 3'h0);
      chk(32'(lat), 32'(ews(i[1:0], wr) + 2));
    end
    rdy_dly = 8'h06;
    rg(1'b1, 4'h4, 32'h0000_0080);
    for (int s = 0; s < 2; s++) begin
      rg(1'b1, 4'h0, 32'h4408_0800 | 32'(s) << 29);
      for (int a = 0; a < 4; a++) begin
        acc(a[1:0], 1'b0, 3'h0);
        if (a == 2) chk(32'(lat), 32'h2);
        else if (s == 0) ls[a] = lat;
        else chk(32'(lat), 32'(ls[a] + 1));
        if (a != 2) chk(32'(lat > 6), 32'h1);
      end
    end
    rdy_dly = 8'hFF;
    berr_req = 1'b1;
    rg(1'b1, 4'h4, 32'h0);
    foreach (tbl[j]) begin
      rg(1'b1, 4'h0, 32'h0008_0800 | 32'(tbl[j][6]) << 25);
      acc(tbl[j][4:3], 1'b0, tbl[j][2:0]);
      chk(32'(err), 32'(tbl[j][5]));
    end
    berr_req = 1'b0;
    finish_test();
  end
endmodule : external_memory_bus_ready_and_config_tb_top

bind emb_ctrl emb_ctrl_chk #(.WIDE_SDRAM(WIDE_SDRAM)) u_emb_ctrl_chk (
  .clk_sys, .srst, .reg_sel, .reg_write, .reg_addr, .req, .rsp, .berr_n,
  .acc_busy, .cmd_done, .sdram_cmd, .ram4_en, .sram_en, .cfg1, .cfg2);
